// *** hdl/mcr_pkg.sv ***
package mcr_pkg;

	////////////////////////////////////////////////////////////////////////
	// Register map and layout
	localparam logic [3:0]  MCR_OFFSET_ONE = 4'h0;
	localparam logic [15:0] MCR_RESET      = 16'h0000;
	// Writable bits; reserved 13, 12, 9, 7, 5 are never stored
	localparam logic [15:0] MCR_WR_MASK    = 16'hCD5F;
	localparam int          MCR_BIT_INH_A  = 15;
	localparam int          MCR_BIT_INH_B  = 14;
	localparam int          MCR_PSEL_HI    = 11;
	localparam int          MCR_PSEL_LO    = 10;
	localparam int          MCR_BIT_MON_EN = 8;
	localparam int          MCR_BIT_RT_EN  = 6;
	localparam int          MCR_BIT_RT_GO  = 4;
	localparam logic [15:0] MCR_MAP1_ADDR  = 16'h000B;

	////////////////////////////////////////////////////////////////////////
	// Serial op codes
	localparam logic [7:0]  MCR_OP_WR      = 8'h10;
	localparam logic [7:0]  MCR_OP_PSEL    = 8'hD8;
	localparam logic [7:0]  MCR_OP_RD      = 8'h80;
	localparam logic [7:0]  MCR_OP_FA_WR   = 8'h40;

	typedef enum logic [5:0] {
		MCR_ST_OP    = 6'h01,
		MCR_ST_WR_HI = 6'h02,
		MCR_ST_WR_LO = 6'h04,
		MCR_ST_RD    = 6'h08,
		MCR_ST_FA_HI = 6'h10,
		MCR_ST_FA_LO = 6'h20
	} mcr_state_e;

	function automatic logic mcr_is_psel(input logic [7:0] op);
		return op[7:2] == MCR_OP_PSEL[7:2];
	endfunction : mcr_is_psel

endpackage : mcr_pkg

// *** hdl/mcr_spi_if.sv ***
`timescale 1ns/100ps
interface mcr_spi_if;
	logic [7:0]  rx_byte;
	logic        byte_vld;
	logic        frame_act;
	logic [15:0] tx_word;
	logic        tx_load;

	modport shift (output rx_byte, byte_vld, frame_act,
		input tx_word, tx_load);
	modport ctrl (input rx_byte, byte_vld, frame_act,
		output tx_word, tx_load);
endinterface : mcr_spi_if

// *** hdl/mcr_spi_shift.sv ***
`timescale 1ns/100ps
module mcr_spi_shift
	import mcr_pkg::*;
(
	input  wire logic clk_sys,
	input  wire logic reset,
	input  wire logic spi_sck,
	input  wire logic spi_cs_n,
	input  wire logic spi_mosi,
	output logic      spi_miso,
	mcr_spi_if.shift  bus
);

	typedef struct packed {
		logic        sck;
		logic [2:0]  cnt;
		logic [7:0]  sh;
		logic [15:0] out_sh;
		logic        miso;
		logic        vld;
		logic        act;
	} mcr_shift_s;

	mcr_shift_s s_q;
	mcr_shift_s s_d;

	////////////////////////////////////////////////////////////////////////
	// Mode 0: sample on rising edge, shift out on falling edge.
	// Edges are seen by oversampling, so sck must stay below clk_sys / 8.
	always_comb begin
		s_d     = s_q;
		s_d.sck = spi_sck;
		s_d.vld = 1'b0;
		s_d.act = !spi_cs_n;
		if (spi_cs_n) begin
			s_d.cnt = 3'h0;
		end else if (spi_sck && !s_q.sck) begin
			s_d.sh  = {s_q.sh[6:0], spi_mosi};
			s_d.cnt = s_q.cnt + 3'h1;
			s_d.vld = s_q.cnt == 3'h7;
		end else if (!spi_sck && s_q.sck) begin
			s_d.miso   = s_q.out_sh[15];
			s_d.out_sh = {s_q.out_sh[14:0], 1'b0};
		end
		// Loaded after the last rising edge, first bit leaves on next fall
		if (bus.tx_load) begin
			s_d.out_sh = bus.tx_word;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign spi_miso      = s_q.miso;
	assign bus.rx_byte   = s_q.sh;
	assign bus.byte_vld  = s_q.vld;
	assign bus.frame_act = s_q.act;

endmodule : mcr_spi_shift

// *** hdl/mcr_master_config.sv ***
// Functional notes
// - The 16-bit register is host read-write and clears on master reset.
// - Monitor and terminal soft resets leave the register untouched.
// - Bit 15 ORed with the bus A pin blocks all bus A transmission.
// - Bit 14 ORed with the bus B pin blocks all bus B transmission.
// - Bits 13, 12, 9, 7 and 5 have no function and read zero.
// - A pointer-select op code is a whole one-byte transaction.
// - Bit 8 enables the monitor, which starts on the first record start.
// - Clearing bit 8 mid-message lets that message finish first.
// - Bit 6 low keeps the terminal off; high lets bit 4 decide.
// - With bit 6 set, bit 4 starts the terminal and clearing it stops it.
`timescale 1ns/100ps
module mcr_master_config
	import mcr_pkg::*;
(
	input  wire logic   clk_sys,
	input  wire logic   reset,
	input  wire logic   master_reset_pin_n,
	input  wire logic   spi_sck,
	input  wire logic   spi_cs_n,
	input  wire logic   spi_mosi,
	output logic        spi_miso,
	input  wire logic   tx_block_pin_a,
	input  wire logic   tx_block_pin_b,
	input  wire logic   monitor_soft_reset,
	input  wire logic   terminal_soft_reset,
	input  wire logic   mon_record_start,
	input  wire logic   mon_msg_busy,
	output logic        tx_block_bus_a,
	output logic        tx_block_bus_b,
	output logic [1:0]  pointer_select_field,
	output logic [15:0] active_pointer_addr,
	output logic [15:0] fast_pointer,
	output logic        monitor_enable_bit,
	output logic        monitor_active,
	output logic        terminal_enable_bit,
	output logic        terminal_start_execution,
	output logic        terminal_running
);

	typedef struct packed {
		mcr_state_e  state;
		logic [15:0] cfg;
		logic [7:0]  hi;
		logic [15:0] fast_ptr;
		logic [15:0] act_ptr;
		logic        mon_act;
		logic        inh_a;
		logic        inh_b;
		logic        rt_run;
		logic        tx_load;
		logic [15:0] tx_word;
	} mcr_state_s;

	localparam mcr_state_s MCR_STATE_RST = '{state: MCR_ST_OP,
		cfg: MCR_RESET, default: '0};

	mcr_state_s s_q;
	mcr_state_s s_d;
	mcr_spi_if  spi ();

	mcr_spi_shift u_shift (
		.clk_sys  (clk_sys),
		.reset    (reset),
		.spi_sck  (spi_sck),
		.spi_cs_n (spi_cs_n),
		.spi_mosi (spi_mosi),
		.spi_miso (spi_miso),
		.bus      (spi.shift)
	);

	////////////////////////////////////////////////////////////////////////
	// Op code decoding; soft resets have no path into this logic
	always_comb begin
		s_d         = s_q;
		s_d.tx_load = 1'b0;
		if (!spi.frame_act) begin
			s_d.state = MCR_ST_OP;
		end else if (spi.byte_vld) begin
			unique case (s_q.state)
				MCR_ST_OP: begin
					if (spi.rx_byte == MCR_OP_WR) begin
						s_d.state = MCR_ST_WR_HI;
					end else if (mcr_is_psel(spi.rx_byte)) begin
						// Stays in op state: no data byte follows
						s_d.cfg[MCR_PSEL_HI:MCR_PSEL_LO] =
							spi.rx_byte[1:0];
					end else if (spi.rx_byte == MCR_OP_RD) begin
						s_d.tx_word = s_q.cfg;
						s_d.tx_load = 1'b1;
						s_d.state   = MCR_ST_RD;
					end else if (spi.rx_byte == MCR_OP_FA_WR) begin
						s_d.state = MCR_ST_FA_HI;
					end
				end
				MCR_ST_WR_HI: begin
					s_d.hi    = spi.rx_byte;
					s_d.state = MCR_ST_WR_LO;
				end
				MCR_ST_WR_LO: begin
					s_d.cfg   = {s_q.hi, spi.rx_byte} & MCR_WR_MASK;
					s_d.state = MCR_ST_OP;
				end
				MCR_ST_FA_HI: begin
					s_d.hi    = spi.rx_byte;
					s_d.state = MCR_ST_FA_LO;
				end
				MCR_ST_FA_LO: begin
					s_d.fast_ptr = {s_q.hi, spi.rx_byte};
					s_d.state    = MCR_ST_OP;
				end
				MCR_ST_RD: begin
					// Extra clocks of a read shift out zeros
				end
			endcase
		end
		s_d.inh_a   = s_q.cfg[MCR_BIT_INH_A] || tx_block_pin_a;
		s_d.inh_b   = s_q.cfg[MCR_BIT_INH_B] || tx_block_pin_b;
		s_d.act_ptr = MCR_MAP1_ADDR
			+ {14'h0000, s_q.cfg[MCR_PSEL_HI:MCR_PSEL_LO]};
		s_d.rt_run  = s_q.cfg[MCR_BIT_RT_EN]
			&& s_q.cfg[MCR_BIT_RT_GO];
		if (!s_q.mon_act) begin
			s_d.mon_act = s_q.cfg[MCR_BIT_MON_EN] && mon_record_start;
		end else if (!s_q.cfg[MCR_BIT_MON_EN] && !mon_msg_busy) begin
			s_d.mon_act = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (reset || !master_reset_pin_n) begin
			s_q <= MCR_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign tx_block_bus_a           = s_q.inh_a;
	assign tx_block_bus_b           = s_q.inh_b;
	assign pointer_select_field     = s_q.cfg[MCR_PSEL_HI:MCR_PSEL_LO];
	assign active_pointer_addr      = s_q.act_ptr;
	assign fast_pointer             = s_q.fast_ptr;
	assign monitor_enable_bit       = s_q.cfg[MCR_BIT_MON_EN];
	assign monitor_active           = s_q.mon_act;
	assign terminal_enable_bit      = s_q.cfg[MCR_BIT_RT_EN];
	assign terminal_start_execution = s_q.cfg[MCR_BIT_RT_GO];
	assign terminal_running         = s_q.rt_run;
	assign spi.tx_word              = s_q.tx_word;
	assign spi.tx_load              = s_q.tx_load;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic rst_any;
	logic op_byte;
	assign rst_any = reset || !master_reset_pin_n;
	assign op_byte = spi.frame_act && spi.byte_vld && s_q.state == MCR_ST_OP;

	property p_mr_clear;
		@(posedge clk_sys) disable iff (reset)
		!master_reset_pin_n |=> s_q.cfg == 16'h0000 && !terminal_running;
	endproperty
	a_mr_clear: assert property (p_mr_clear)
		else $error("config not cleared by master reset");

	property p_soft_keep;
		@(posedge clk_sys) disable iff (rst_any)
		(monitor_soft_reset || terminal_soft_reset)
			&& !spi.byte_vld |=> $stable(s_q.cfg);
	endproperty
	a_soft_keep: assert property (p_soft_keep)
		else $error("config changed on soft reset");

	property p_inh_a;
		@(posedge clk_sys) disable iff (rst_any)
		tx_block_pin_a |=> tx_block_bus_a;
	endproperty
	a_inh_a: assert property (p_inh_a)
		else $error("bus A pin did not block transmit");

	property p_inh_b;
		@(posedge clk_sys) disable iff (rst_any)
		s_q.cfg[MCR_BIT_INH_B] && !spi.byte_vld |=> ##1 tx_block_bus_b;
	endproperty
	a_inh_b: assert property (p_inh_b)
		else $error("bus B bit did not block transmit");

	property p_rsvd;
		@(posedge clk_sys) disable iff (rst_any)
		s_q.tx_load |-> (s_q.tx_word & ~MCR_WR_MASK) == 16'h0000;
	endproperty
	a_rsvd: assert property (p_rsvd)
		else $error("reserved bit read as one");

	property p_psel;
		@(posedge clk_sys) disable iff (rst_any)
		op_byte && mcr_is_psel(spi.rx_byte) |=>
			pointer_select_field == $past(spi.rx_byte[1:0])
			&& s_q.state == MCR_ST_OP
			&& ((s_q.cfg ^ $past(s_q.cfg)) & 16'hF3FF) == 16'h0000
			##1 active_pointer_addr == MCR_MAP1_ADDR
			+ {14'h0000, pointer_select_field};
	endproperty
	a_psel: assert property (p_psel)
		else $error("pointer select op code misbehaved");

	property p_mon_start;
		@(posedge clk_sys) disable iff (rst_any)
		!monitor_active && monitor_enable_bit && mon_record_start
			|=> monitor_active;
	endproperty
	a_mon_start: assert property (p_mon_start)
		else $error("monitor did not start");

	property p_mon_finish;
		@(posedge clk_sys) disable iff (rst_any)
		monitor_active && mon_msg_busy |=> monitor_active;
	endproperty
	a_mon_finish: assert property (p_mon_finish)
		else $error("monitor stopped mid-message");

	property p_rt_off;
		@(posedge clk_sys) disable iff (rst_any)
		!terminal_enable_bit [*2] |-> !terminal_running;
	endproperty
	a_rt_off: assert property (p_rt_off)
		else $error("terminal ran while disabled");

	property p_rt_go;
		@(posedge clk_sys) disable iff (rst_any)
		(terminal_enable_bit && terminal_start_execution) [*2]
			|-> terminal_running;
	endproperty
	a_rt_go: assert property (p_rt_go)
		else $error("terminal not running when started");

	property p_fast;
		@(posedge clk_sys) disable iff (rst_any)
		spi.frame_act && spi.byte_vld && s_q.state == MCR_ST_FA_LO |=>
			fast_pointer == {s_q.hi, $past(spi.rx_byte)}
			&& $stable(pointer_select_field);
	endproperty
	a_fast: assert property (p_fast)
		else $error("fast pointer write wrong");

	c_write: cover property (@(posedge clk_sys)
		spi.byte_vld && s_q.state == MCR_ST_WR_LO);
	c_psel: cover property (@(posedge clk_sys)
		op_byte && mcr_is_psel(spi.rx_byte));
	c_read: cover property (@(posedge clk_sys) s_q.tx_load);
	c_mon_tail: cover property (@(posedge clk_sys)
		monitor_active && !monitor_enable_bit && mon_msg_busy);

endmodule : mcr_master_config

// *** verif/mcr_host_model.sv ***
`timescale 1ns/100ps
// Host side of the serial port; sck stands low between frames
module mcr_host_model
	import mcr_pkg::*;
(
	input  wire logic clk_sys,
	output logic      spi_sck,
	output logic      spi_cs_n,
	output logic      spi_mosi,
	input  wire logic spi_miso
);
	initial begin
		spi_sck  = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end
	////////////////////////////////////////////////////////////////////////
	// Half period of 5 clocks keeps sck below clk_sys/8
	task automatic xbyte(input logic [7:0] b, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			@(posedge clk_sys);
			spi_sck  <= 1'b0;
			spi_mosi <= b[i];
			repeat (4) @(posedge clk_sys);
			@(negedge clk_sys);
			r[i] = spi_miso;
			@(posedge clk_sys);
			spi_sck <= 1'b1;
			repeat (4) @(posedge clk_sys);
		end
	endtask : xbyte
	task automatic open_frame;
		@(posedge clk_sys);
		spi_cs_n <= 1'b0;
		repeat (4) @(posedge clk_sys);
	endtask : open_frame
	// Released data line flips so a stale bit is never mistaken for data
	task automatic close_frame;
		@(posedge clk_sys);
		spi_sck <= 1'b0;
		repeat (4) @(posedge clk_sys);
		spi_cs_n <= 1'b1;
		spi_mosi <= ~spi_mosi;
		repeat (8) @(posedge clk_sys);
	endtask : close_frame
	////////////////////////////////////////////////////////////////////////
	task automatic wr_word(input logic [7:0] op, input logic [15:0] w);
		logic [7:0] r;
		open_frame();
		xbyte(op, r);
		xbyte(w[15:8], r);
		xbyte(w[7:0], r);
		close_frame();
	endtask : wr_word
	// Two select op codes back to back, each a whole transaction
	task automatic psel(input logic [7:0] a, input logic [7:0] b);
		logic [7:0] r;
		open_frame();
		xbyte(a, r);
		xbyte(b, r);
		close_frame();
	endtask : psel
	task automatic rd_word(output logic [15:0] w);
		logic [7:0] r;
		logic [7:0] h;
		open_frame();
		xbyte(MCR_OP_RD, r);
		xbyte(8'h00, h);
		xbyte(8'h00, r);
		w = {h, r};
		close_frame();
	endtask : rd_word
endmodule : mcr_host_model

// *** verif/mcr_master_config_tb_top.sv ***
`timescale 1ns/100ps
module mcr_master_config_tb_top;
	import mcr_pkg::*;
	typedef struct packed {
		logic [15:0] wr;
		logic        pa;
		logic        pb;
		logic [15:0] rd;
		logic [2:0]  exp;
	} mcr_row_s;
	// exp holds bus A block, bus B block, terminal running
	localparam mcr_row_s ROWS [6] = '{
		'{16'hFFFF, 1'b0, 1'b0, 16'hCD5F, 3'b111},
		'{16'h0000, 1'b1, 1'b0, 16'h0000, 3'b100},
		'{16'h0000, 1'b0, 1'b1, 16'h0000, 3'b010},
		'{16'h8010, 1'b0, 1'b0, 16'h8010, 3'b100},
		'{16'h4050, 1'b0, 1'b0, 16'h4050, 3'b011},
		'{16'h0040, 1'b0, 1'b0, 16'h0040, 3'b000}};
	logic        clk_sys, reset, mr_n, sck, cs_n, mosi, miso, pa, pb;
	logic        msr, tsr, rec, busy, tx_a, tx_b, mon_act, rt_run;
	logic        mon_en, rt_en, rt_go;
	logic [1:0]  psel;
	logic [15:0] ptr, fptr, rd;
	int          fails, check_count, cycles;
	mcr_master_config u_dut (
		.clk_sys                  (clk_sys),
		.reset                    (reset),
		.master_reset_pin_n       (mr_n),
		.spi_sck                  (sck),
		.spi_cs_n                 (cs_n),
		.spi_mosi                 (mosi),
		.spi_miso                 (miso),
		.tx_block_pin_a           (pa),
		.tx_block_pin_b           (pb),
		.monitor_soft_reset       (msr),
		.terminal_soft_reset      (tsr),
		.mon_record_start         (rec),
		.mon_msg_busy             (busy),
		.tx_block_bus_a           (tx_a),
		.tx_block_bus_b           (tx_b),
		.pointer_select_field     (psel),
		.active_pointer_addr      (ptr),
		.fast_pointer             (fptr),
		.monitor_enable_bit       (mon_en),
		.monitor_active           (mon_act),
		.terminal_enable_bit      (rt_en),
		.terminal_start_execution (rt_go),
		.terminal_running         (rt_run)
	);
	mcr_host_model u_host (.clk_sys(clk_sys), .spi_sck(sck),
		.spi_cs_n(cs_n), .spi_mosi(mosi), .spi_miso(miso));
	////////////////////////////////////////////////////////////////////////
	always #12.5 clk_sys = ~clk_sys;
	task automatic chk(input string nm, input logic [15:0] e,
		input logic [15:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	task automatic end_of_test;
		$display("Checks %0d, failures %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : end_of_test
	// Ceiling well above the roughly 6900 cycles the sequence needs
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == 40000) begin
			fails++;
			end_of_test();
		end
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		{clk_sys, pa, pb, msr, tsr, rec, busy} = '0;
		{fails, check_count, cycles} = '0;
		reset = 1'b1;
		mr_n  = 1'b1;
		repeat (2) @(posedge clk_sys);
		reset <= 1'b0;
		u_host.rd_word(rd);
		chk("reset value", 16'h0000, rd);
		foreach (ROWS[i]) begin
			@(posedge clk_sys);
			pa <= ROWS[i].pa;
			pb <= ROWS[i].pb;
			u_host.wr_word(MCR_OP_WR, ROWS[i].wr);
			u_host.rd_word(rd);
			chk("readback", ROWS[i].rd, rd);
			chk("tx a", ROWS[i].exp[2], tx_a);
			chk("tx b", ROWS[i].exp[1], tx_b);
			chk("rt run", ROWS[i].exp[0], rt_run);
			chk("mon en", ROWS[i].rd[MCR_BIT_MON_EN], mon_en);
			chk("rt en", ROWS[i].rd[MCR_BIT_RT_EN], rt_en);
			chk("rt go", ROWS[i].rd[MCR_BIT_RT_GO], rt_go);
			chk("row ptr", 16'h000B + ROWS[i].rd[11:10], ptr);
		end
		@(posedge clk_sys);
		pb <= 1'b0;
		// Last op of each frame wins; bits outside 11:10 stay put
		for (int i = 0; i < 4; i++) begin
			u_host.psel(8'hDB, MCR_OP_PSEL + 8'(i));
			chk("select", 16'(i), psel);
			chk("pointer", 16'h000B + 16'(i), ptr);
			u_host.rd_word(rd);
			chk("select rd", 16'h0040 | 16'(i << 10), rd);
		end
		@(posedge clk_sys);
		msr <= 1'b1;
		tsr <= 1'b1;
		u_host.rd_word(rd);
		chk("soft reset", 16'h0C40, rd);
		msr <= 1'b0;
		tsr <= 1'b0;
		u_host.wr_word(MCR_OP_FA_WR, 16'h1234);
		u_host.rd_word(rd);
		chk("fast ptr", 16'h1234, fptr);
		chk("fast rd", 16'h0C40, rd);
		u_host.wr_word(MCR_OP_WR, 16'h0100);
		chk("mon en on", 16'h1, mon_en);
		chk("mon idle", 16'h0, mon_act);
		@(posedge clk_sys);
		rec <= 1'b1;
		@(posedge clk_sys);
		rec  <= 1'b0;
		busy <= 1'b1;
		repeat (3) @(posedge clk_sys);
		chk("mon start", 16'h1, mon_act);
		u_host.wr_word(MCR_OP_WR, 16'h0000);
		chk("mon en off", 16'h0, mon_en);
		chk("mon finish", 16'h1, mon_act);
		busy <= 1'b0;
		repeat (3) @(posedge clk_sys);
		chk("mon stop", 16'h0, mon_act);
		u_host.wr_word(MCR_OP_WR, 16'hCD5F);
		@(posedge clk_sys);
		mr_n <= 1'b0;
		@(posedge clk_sys);
		mr_n <= 1'b1;
		u_host.rd_word(rd);
		chk("master reset", 16'h0000, rd);
		chk("mr tx a", 16'h0, tx_a);
		end_of_test();
	end
endmodule : mcr_master_config_tb_top
